// *** hdl/clk_prescaler.sv ***
// prescaler making divide-by-8/32 enables and the sub-clock tap
`timescale 1ns/1ps
module clk_prescaler (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sub_rise,
    output logic      tick_div8,
    output logic      tick_div32,
    output logic      tick_sub32
);
    logic [4:0] pre_q;
    logic [4:0] sub_q;

    // pre_q free-runs, sub_q steps only on sub-clock rises; wrap at 32 is natural for 5 bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= timer_pkg::PRE_RESET;
            sub_q <= timer_pkg::PRE_RESET;
        end else begin
            pre_q <= pre_q + timer_pkg::PRE_ONE;
            if (sub_rise) begin
                sub_q <= sub_q + timer_pkg::PRE_ONE;
            end
        end
    end

    // one-cycle enables, never a derived clock
    assign tick_div8  = (pre_q & timer_pkg::DIV8_LAST)
                        == timer_pkg::DIV8_LAST;
    assign tick_div32 = pre_q == timer_pkg::DIV32_LAST;
    assign tick_sub32 = sub_rise && (sub_q == timer_pkg::DIV32_LAST);
endmodule

// *** hdl/general_timer_interval_event.sv ***
// 16-bit timer channel: interval mode and single-phase event mode
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module general_timer_interval_event (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        count_input_pin,
    input  wire logic        subclk,
    input  wire logic        sibling_timer_b1_ovf,
    input  wire logic        sibling_timer_x0_ovf,
    input  wire logic        sibling_timer_x2_ovf,
    input  wire logic        timer_output_pin_in,
    output logic             timer_output_pin_out,
    output logic             timer_output_pin_oe,
    output logic             irq
);
    timer_pkg::mode_s mode_q;
    logic [15:0]      cnt_q;
    logic [15:0]      cnt_d;
    logic [15:0]      reload_q;
    logic [15:0]      reload_d;
    logic             start_q;
    logic             tout_q;
    logic             toe_q;
    logic             irq_q;
    logic [15:0]      rdata_q;
    logic [15:0]      rdata_d;

    // synchronised pins: bit0 count input, bit1 output pin, bit2 sub
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    pin_sync #(
        .W (3)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .pin  ({subclk, timer_output_pin_in, count_input_pin}),
        .lvl  (pin_lvl),
        .rise (pin_rise),
        .fall (pin_fall)
    );

    logic tick_div8;
    logic tick_div32;
    logic tick_sub32;

    clk_prescaler u_pre (
        .clk        (clk),
        .rst        (rst),
        .sub_rise   (pin_rise[2]),
        .tick_div8  (tick_div8),
        .tick_div32 (tick_div32),
        .tick_sub32 (tick_sub32)
    );

    // register decode
    wire wr_mode  = wr && (addr == timer_pkg::ADDR_MODE);
    wire wr_tmr   = wr && (addr == timer_pkg::ADDR_TIMER);
    wire wr_start = wr && (addr == timer_pkg::ADDR_START);
    wire rd_mode  = rd && (addr == timer_pkg::ADDR_MODE);
    wire rd_tmr   = rd && (addr == timer_pkg::ADDR_TIMER);
    wire rd_start = rd && (addr == timer_pkg::ADDR_START);

    // reserved mode bits are dropped so they always read zero
    wire timer_pkg::mode_s mode_wr =
        timer_pkg::mode_s'({timer_pkg::MODE_RSVD, wdata[10:0]});

    // mode decode from the low two bits
    wire is_int = mode_q.mode == timer_pkg::OP_INTERVAL;
    wire is_evt = mode_q.mode == timer_pkg::OP_EVENT;

    // interval count source: one of four taps
    logic int_src;
    always_comb begin
        case (mode_q.src)
            timer_pkg::SRC_DIV1:  int_src = 1'b1;
            timer_pkg::SRC_DIV8:  int_src = tick_div8;
            timer_pkg::SRC_DIV32: int_src = tick_div32;
            default:              int_src = tick_sub32;
        endcase
    end

    // event source: chosen pin edge or a sibling overflow
    wire pin_edge = mode_q.edge_rise ? pin_rise[0] : pin_fall[0];
    logic evt_src;
    always_comb begin
        case (mode_q.src)
            timer_pkg::SRC_PIN:    evt_src = pin_edge;
            timer_pkg::SRC_SIB_B1: evt_src = sibling_timer_b1_ovf;
            timer_pkg::SRC_SIB_X0: evt_src = sibling_timer_x0_ovf;
            default:               evt_src = sibling_timer_x2_ovf;
        endcase
    end

    // gate opens while the pin sits at its configured level
    wire gate_open = !mode_q.gate_en
                     || (pin_lvl[0] == mode_q.gate_lvl);

    // one-shot and pwm codes are not built here and never count
    wire tick = start_q && ((is_int && int_src && gate_open)
                            || (is_evt && evt_src));

    // output pin turns input when it selects the direction
    wire dir_pin   = is_evt && mode_q.dir_ext;
    wire count_up  = is_evt && (mode_q.dir_ext ? pin_lvl[1]
                                               : mode_q.dir_up);
    wire at_end    = count_up ? (cnt_q == timer_pkg::CNT_MAX)
                              : (cnt_q == timer_pkg::CNT_ZERO);
    wire wrap_ev   = tick && at_end;
    wire free_wrap = is_evt && mode_q.free_run;
    wire pulse_drv = mode_q.pulse_en && !dir_pin;

    // plus/minus one step; the 16-bit wrap gives free-run for free
    wire [15:0] cnt_step = count_up ? cnt_q + timer_pkg::CNT_ONE
                                    : cnt_q - timer_pkg::CNT_ONE;

    // counter next value; a stopped write beats everything
    always_comb begin
        cnt_d = cnt_q;
        if (wr_tmr && !start_q) begin
            cnt_d = wdata;
        end else if (wrap_ev && !free_wrap) begin
            cnt_d = reload_q;
        end else if (tick) begin
            cnt_d = cnt_step;
        end
    end

    // reload takes every timer write; a running counter sees it at wrap, a stopped one at once
    assign reload_d = wr_tmr ? wdata : reload_q;

    // read mux, answered in the following cycle
    always_comb begin
        rdata_d = timer_pkg::RDATA_RESET;
        if (rd_mode) begin
            rdata_d = mode_q;
        end else if (rd_tmr) begin
            rdata_d = cnt_q;
        end else if (rd_start) begin
            rdata_d = {14'h0000, tout_q, start_q};
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q  <= timer_pkg::mode_s'(timer_pkg::MODE_RESET);
            start_q <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_q <= mode_wr;
            end
            if (wr_start) begin
                start_q <= wdata[0];
            end
        end
    end

    // counter and reload, sixteen bits each
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= timer_pkg::CNT_ZERO;
            reload_q <= timer_pkg::RELOAD_RESET;
        end else begin
            cnt_q    <= cnt_d;
            reload_q <= reload_d;
        end
    end

    // pulse output flips on each wrap while pulse_drv is set; request is a one-cycle pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tout_q  <= 1'b0;
            toe_q   <= 1'b0;
            irq_q   <= 1'b0;
            rdata_q <= timer_pkg::RDATA_RESET;
        end else begin
            if (wrap_ev && pulse_drv) begin
                tout_q <= !tout_q;
            end
            toe_q   <= pulse_drv;
            irq_q   <= wrap_ev;
            rdata_q <= rdata_d;
        end
    end

    assign rdata                = rdata_q;
    assign timer_output_pin_out = tout_q;
    assign timer_output_pin_oe  = toe_q;
    assign irq                  = irq_q;

    // checks on the design's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_int_reload;
        is_int && wrap_ev && !wr_tmr |=> cnt_q == $past(reload_q);
    endproperty
    a_int_reload: assert property (p_int_reload)
        else $error("interval underflow did not reload");

    property p_int_step;
        is_int && tick && !at_end
        |=> cnt_q == $past(cnt_q) - timer_pkg::CNT_ONE;
    endproperty
    a_int_step: assert property (p_int_step)
        else $error("interval count did not decrement by one");

    property p_halt;
        !start_q && !wr_tmr |=> $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter moved while stopped");

    property p_req;
        wrap_ev |=> irq ##1 (!irq || $past(wrap_ev));
    endproperty
    a_req: assert property (p_req)
        else $error("request missing or too long on wrap");

    property p_read;
        rd_tmr |=> rdata == $past(cnt_q);
    endproperty
    a_read: assert property (p_read)
        else $error("timer read did not return counter");

    property p_stop_wr;
        wr_tmr && !start_q
        |=> cnt_q == $past(wdata) && reload_q == $past(wdata);
    endproperty
    a_stop_wr: assert property (p_stop_wr)
        else $error("stopped write missed counter or reload");

    property p_run_wr;
        wr_tmr && start_q && !tick
        |=> reload_q == $past(wdata) && cnt_q == $past(cnt_q);
    endproperty
    a_run_wr: assert property (p_run_wr)
        else $error("running write touched the counter");

    property p_gate;
        is_int && start_q && !gate_open && !wr_tmr |=> $stable(cnt_q);
    endproperty
    a_gate: assert property (p_gate)
        else $error("closed gate let the counter move");

    property p_toggle;
        wrap_ev && pulse_drv |=> tout_q != $past(tout_q);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("pulse output did not toggle on wrap");

    property p_free;
        free_wrap && wrap_ev && !count_up && !wr_tmr
        |=> cnt_q == timer_pkg::CNT_MAX;
    endproperty
    a_free: assert property (p_free)
        else $error("free-run underflow did not wrap to max");

    property p_up_reload;
        is_evt && count_up && wrap_ev && !free_wrap && !wr_tmr
        |=> cnt_q == $past(reload_q);
    endproperty
    a_up_reload: assert property (p_up_reload)
        else $error("event overflow did not reload");

    property p_dir_pin;
        dir_pin |=> !timer_output_pin_oe;
    endproperty
    a_dir_pin: assert property (p_dir_pin)
        else $error("output pin driven while used as input");

    // unselected siblings must leave the count alone
    property p_evt_src;
        is_evt && mode_q.src == timer_pkg::SRC_SIB_X0
        && !sibling_timer_x0_ovf && !wr_tmr |=> $stable(cnt_q);
    endproperty
    a_evt_src: assert property (p_evt_src)
        else $error("unselected source moved the event count");

    // direction comes from the pin or the software bit
    property p_evt_dir;
        is_evt && tick && !at_end
        |=> cnt_q == (($past(mode_q.dir_ext) ? $past(pin_lvl[1])
                                             : $past(mode_q.dir_up))
                      ? $past(cnt_q) + timer_pkg::CNT_ONE
                      : $past(cnt_q) - timer_pkg::CNT_ONE);
    endproperty
    a_evt_dir: assert property (p_evt_dir)
        else $error("event count stepped the wrong way");

    // the pulse output only moves on a driven wrap
    property p_hold_out;
        !(wrap_ev && pulse_drv) |=> $stable(tout_q);
    endproperty
    a_hold_out: assert property (p_hold_out)
        else $error("pulse output moved without a wrap");

    // the divide-by-8 tap lets the counter move only on its tick
    property p_div8_tap;
        is_int && mode_q.src == timer_pkg::SRC_DIV8 && !tick_div8
        && !wr_tmr |=> $stable(cnt_q);
    endproperty
    a_div8_tap: assert property (p_div8_tap)
        else $error("interval counted between prescaler ticks");

    // a request never appears without a wrap behind it
    property p_irq_only;
        irq |-> $past(wrap_ev);
    endproperty
    a_irq_only: assert property (p_irq_only)
        else $error("request raised without a wrap");

    c_int_wrap: cover property (is_int && wrap_ev);
    c_evt_up:   cover property (is_evt && count_up && wrap_ev);
    c_free:     cover property (free_wrap && wrap_ev);
    c_gate:     cover property (is_int && start_q && !gate_open);
    c_run_wr:   cover property (wr_tmr && start_q ##[1:40] wrap_ev);
endmodule

// *** hdl/pin_sync.sv ***
// two-flop synchroniser with edge detect for external pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // meta_q feeds sync_q only; edges compare sync and prev
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign lvl  = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule

// *** hdl/timer_pkg.sv ***
// shared constants, register map and mode field layout for the timer
package timer_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // register byte offsets
    localparam logic [3:0] ADDR_MODE  = 4'h0;
    localparam logic [3:0] ADDR_TIMER = 4'h4;
    localparam logic [3:0] ADDR_START = 4'h8;

    // counter limits and values after reset
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] RDATA_RESET  = 16'h0000;
    localparam logic [15:0] MODE_RESET   = 16'h0000;
    localparam logic [4:0]  MODE_RSVD    = 5'h00;

    // prescaler taps: divide by 8 and 32 on one 5-bit counter
    localparam logic [4:0] PRE_RESET  = 5'h00;
    localparam logic [4:0] PRE_ONE    = 5'h01;
    localparam logic [4:0] DIV8_LAST  = 5'h07;
    localparam logic [4:0] DIV32_LAST = 5'h1F;

    // operating mode, bits 1:0 of the mode register
    typedef enum logic [1:0] {
        OP_INTERVAL = 2'h0,
        OP_EVENT    = 2'h1,
        OP_ONESHOT  = 2'h2,
        OP_PWM      = 2'h3
    } op_mode_e;

    // count source select: interval taps / event sources
    localparam logic [1:0] SRC_DIV1    = 2'h0;
    localparam logic [1:0] SRC_DIV8    = 2'h1;
    localparam logic [1:0] SRC_DIV32   = 2'h2;
    localparam logic [1:0] SRC_SUB32   = 2'h3;
    localparam logic [1:0] SRC_PIN     = 2'h0;
    localparam logic [1:0] SRC_SIB_B1  = 2'h1;
    localparam logic [1:0] SRC_SIB_X0  = 2'h2;
    localparam logic [1:0] SRC_SIB_X2  = 2'h3;

    // mode register layout, msb first
    typedef struct packed {
        logic [4:0] rsvd;
        logic [1:0] src;
        logic       dir_up;
        logic       dir_ext;
        logic       free_run;
        logic       edge_rise;
        logic       gate_lvl;
        logic       gate_en;
        logic       pulse_en;
        op_mode_e   mode;
    } mode_s;
endpackage

// *** test/ext_source.sv ***
// partner model: event pin, sub-clock, sibling overflows and direction pin
`timescale 1ns/1ps
module ext_source (
    input  wire logic clk,
    output logic      count_input_pin,
    output logic      subclk,
    output logic      sib_b1,
    output logic      sib_x0,
    output logic      sib_x2,
    output logic      dir_pin
);
    // sub-clock oscillator runs free, unrelated in phase to clk
    initial begin
        {count_input_pin, sib_b1, sib_x0, sib_x2, dir_pin} = 5'h00;
        subclk = 1'b0;
        forever #170 subclk = ~subclk;
    end

    // wide pulses, so the two-flop sync never misses one
    task automatic pulses(int n);
        repeat (n) begin
            @(posedge clk) count_input_pin <= 1'b1;
            repeat (4) @(posedge clk);
            count_input_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // one-cycle overflow pulses on the chosen sibling, noise on the rest
    task automatic sib(logic [1:0] s, int n);
        logic [2:0] sel;
        sel = 3'h1 << (s - 2'h1);
        repeat (n) begin
            @(posedge clk) {sib_x2, sib_x0, sib_b1} <= sel | noise(sel);
            @(posedge clk) {sib_x2, sib_x0, sib_b1} <= noise(sel);
            @(posedge clk) {sib_x2, sib_x0, sib_b1} <= 3'h0;
        end
    endtask

    // random pulses on the lines that must not count
    function automatic logic [2:0] noise(logic [2:0] sel);
        return 3'($urandom) & ~sel;
    endfunction

    // static levels for gating and direction
    task automatic set_pin(logic v);
        @(posedge clk) count_input_pin <= v;
    endtask
    task automatic set_dir(logic v);
        @(posedge clk) dir_pin <= v;
    endtask
endmodule

// *** test/general_timer_interval_event_tb.sv ***
// self-checking bench for the interval/event timer channel
`timescale 1ns/1ps
module general_timer_interval_event_tb;
    logic        clk, rst, wr, rd, rd_q, sub, b1, x0, x2, pin, dir;
    logic        out, oe, irq, p;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v, n;
    logic [15:0] exp_q[$];
    int          miscompares, n_checks, n_irq, cyc, last, gap, t;
    // pin level: the block wins while it drives, else the partner
    wire         io_lvl = oe ? out : dir;

    general_timer_interval_event u_dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .count_input_pin(pin), .subclk(sub), .sibling_timer_b1_ovf(b1),
        .sibling_timer_x0_ovf(x0), .sibling_timer_x2_ovf(x2),
        .timer_output_pin_in(io_lvl), .timer_output_pin_out(out),
        .timer_output_pin_oe(oe), .irq(irq));
    ext_source u_src (.clk(clk), .count_input_pin(pin), .subclk(sub),
        .sib_b1(b1), .sib_x0(x0), .sib_x2(x2), .dir_pin(dir));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // monitor: irq spacing, and read data one cycle after each strobe
    always @(posedge clk) begin
        cyc++;
        if (irq === 1'b1) begin
            n_irq++;
            gap = cyc - last;
            last = cyc;
        end
        if (rd_q === 1'b1)
            check(rdata, exp_q.pop_front());
        rd_q <= rd;
    end

    task automatic check(logic [15:0] seen, logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t ns: seen %h, expected %h",
                     $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic wr_reg(logic [3:0] a, logic [15:0] d);
        @(posedge clk) begin
            wr <= 1'b1;
            addr <= a;
            wdata <= d;
        end
        @(posedge clk) wr <= 1'b0;
    endtask

    // expectation noted now, compared by the monitor
    task automatic rd_reg(logic [3:0] a, logic [15:0] want);
        @(posedge clk) begin
            rd <= 1'b1;
            addr <= a;
            exp_q.push_back(want);
        end
        @(posedge clk) rd <= 1'b0;
    endtask

    task automatic go(logic b);
        wr_reg(timer_pkg::ADDR_START, {15'h0000, b});
    endtask
    task automatic set_timer(logic [15:0] d);
        wr_reg(timer_pkg::ADDR_TIMER, d);
    endtask
    task automatic rd_timer(logic [15:0] d);
        rd_reg(timer_pkg::ADDR_TIMER, d);
    endtask

    // bounded wait for k more requests; running dry is a failure
    task automatic wait_irqs(int k);
        int t0;
        t0 = n_irq;
        for (int i = 0; i < 3000 && n_irq < t0 + k; i++) @(posedge clk);
        @(negedge clk);
        if (n_irq < t0 + k) begin
            miscompares++;
            complete_run();
        end
    endtask

    // events then sync latency, then count requests since t
    task automatic ev(int k, int want);
        u_src.pulses(k);
        repeat (4) @(posedge clk);
        check(16'(n_irq - t), 16'(want));
    endtask

    // opt bits: dir_up dir_ext free_run edge_rise gate_lvl gate_en pulse_en
    function automatic logic [15:0] md(logic [1:0] s, logic [6:0] o,
                                       timer_pkg::op_mode_e m);
        return {timer_pkg::MODE_RSVD, s, o, m};
    endfunction

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        v = 16'($urandom(76));
        rd_reg(timer_pkg::ADDR_MODE, timer_pkg::MODE_RESET);
        rd_timer(timer_pkg::RELOAD_RESET);
        rd_reg(timer_pkg::ADDR_START, 16'h0000);
        rd_reg(4'hC | 4'($urandom % 4), timer_pkg::RDATA_RESET);
        wr_reg(timer_pkg::ADDR_MODE, 16'hF87C);
        rd_reg(timer_pkg::ADDR_MODE, 16'h007C);
        set_timer(v);
        rd_timer(v);
        // interval, div1, random period, pulse output on
        n = 16'(2 + $urandom % 8);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_DIV1, 7'h01,
                                        timer_pkg::OP_INTERVAL));
        set_timer(n);
        go(1'b1);
        wait_irqs(1);
        p = out;
        wait_irqs(1);
        check(16'(gap), n + 16'h0001);
        check({15'h0000, out}, {15'h0000, !p});
        check({15'h0000, oe}, 16'h0001);
        // running write lands at a reload, never at once
        set_timer(16'h0002);
        wait_irqs(3);
        check(16'(gap), 16'h0003);
        // prescaler taps with n=1: two ticks per period
        for (int s = 1; s < 4; s++) begin
            go(1'b0);
            wr_reg(timer_pkg::ADDR_MODE, md(s[1:0], 7'h00,
                                            timer_pkg::OP_INTERVAL));
            set_timer(16'h0001);
            go(1'b1);
            wait_irqs(2);
            if (s < 3)
                check(16'(gap), 16'(s == 1 ? 16 : 64));
            else
                check(16'(gap > 300 && gap < 600), 16'h0001);
        end
        // gate active high: low pin blocks, high pin runs
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_DIV1, 7'h06,
                                        timer_pkg::OP_INTERVAL));
        set_timer(16'h0003);
        u_src.set_pin(1'b0);
        go(1'b1);
        t = n_irq;
        repeat (40) @(posedge clk);
        check(16'(n_irq - t), 16'h0000);
        rd_timer(16'h0003);
        u_src.set_pin(1'b1);
        wait_irqs(1);
        // event, rising edges, down; stopped first so nothing counts
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_PIN, 7'h09,
                                        timer_pkg::OP_EVENT));
        u_src.set_pin(1'b0);
        set_timer(16'h0002);
        u_src.pulses(2);
        rd_timer(16'h0002);
        p = out;
        go(1'b1);
        t = n_irq;
        ev(3, 1);
        check({15'h0000, out}, {15'h0000, !p});
        ev(2, 1);
        rd_timer(16'h0000);
        // up count on falling edges: FFFF - n + 1 events
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_PIN, 7'h40,
                                        timer_pkg::OP_EVENT));
        set_timer(16'hFFFD);
        go(1'b1);
        t = n_irq;
        ev(3, 1);
        rd_timer(16'hFFFD);
        // each sibling overflow as the source
        for (int s = 1; s < 4; s++) begin
            go(1'b0);
            wr_reg(timer_pkg::ADDR_MODE, md(s[1:0], 7'h00,
                                            timer_pkg::OP_EVENT));
            set_timer(16'h0001);
            go(1'b1);
            t = n_irq;
            u_src.sib(s[1:0], 2);
            repeat (3) @(posedge clk);
            check(16'(n_irq - t), 16'h0001);
        end
        // pwm code three is not built, so the counter must sit
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_DIV1, 7'h00,
                                        timer_pkg::OP_PWM));
        set_timer(16'h0007);
        go(1'b1);
        repeat (10) @(posedge clk);
        rd_timer(16'h0007);
        // free-run wraps to zero instead of reloading
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_PIN, 7'h58,
                                        timer_pkg::OP_EVENT));
        set_timer(16'hFFFE);
        go(1'b1);
        u_src.pulses(2);
        rd_timer(16'h0000);
        // direction from the output pin: low down, high up
        go(1'b0);
        wr_reg(timer_pkg::ADDR_MODE, md(timer_pkg::SRC_PIN, 7'h28,
                                        timer_pkg::OP_EVENT));
        set_timer(16'h0005);
        u_src.set_dir(1'b0);
        go(1'b1);
        u_src.pulses(1);
        rd_timer(16'h0004);
        u_src.set_dir(1'b1);
        repeat (4) @(posedge clk);
        u_src.pulses(2);
        rd_timer(16'h0006);
        check({15'h0000, oe}, 16'h0000);
        repeat (4) @(posedge clk);
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
